// [sar_readout_pkg.sv]
// Shared constants and carrier types for the converter readout block
package sar_readout_pkg;
  localparam int RES_BITS = 10;
  localparam int LEAD_ZEROS = 2;
  localparam int SHIFT_EDGES = 12;
  localparam int PWRUP_CAL_EDGES = 16;
  localparam int CAL_START_EDGE = 17;
  localparam int CAL_DONE_EDGE = 32;
  localparam int EDGE_CNT_W = 6;
  localparam logic [9:0] NEG_FULL_SCALE_CODE = 10'h000;
  localparam logic [9:0] MID_SCALE_CODE = 10'h200;
  localparam logic [9:0] POS_FULL_SCALE_CODE = 10'h3FF;
  localparam logic [9:0] OFFSET_RESET = 10'h000;
  localparam int SETUP_NS = 15;
  localparam int ACQ_NS = 235;

  typedef struct packed {
    logic [9:0] code;
    logic valid;
  } sample_s;

  typedef struct packed {
    logic sdo;
    logic sdo_oe;
    logic inputs_connected;
  } pin_out_s;
endpackage

// [sar_readout_cal.sv]
// Serial readout, conversion sequencing and offset calibration of the converter
// Function
// - A frame opens on select fall and closes on select rise.
// - Select fall captures the input difference and starts converting.
// - Conversion and shifting are stepped by the host serial clock only.
// - Select fall enables data output and presents a leading zero.
// - Each later clock fall launches a second zero, then result bits.
// - After twelve clocks the data output stays low for the frame.
// - Select rise ends the frame and releases the data output.
// - Result is 10-bit unsigned straight binary.
// - Ideal codes 000, 200, 3FF at negative, mid and positive scale.
// - Inputs isolated while converting, reconnected for acquisition afterwards.
// - Calibration starts at power-up or on host demand.
// - Calibration begins at first frame after power-up; output held low.
// - Inputs stay disconnected from the sampler during calibration.
// - Offset result lives in an internal, serially unreachable store.
// - Offset store clears to zero at power-up.
// - Only a supply power cycle clears the stored offset.
// - Power-up calibration needs sixteen clock falls, else store unchanged.
// - Long frame calibrates edges 17 to 32; shorter frames leave store.
// - Later results are corrected by the stored offset before shifting.
`timescale 1ns/1ps
`default_nettype none
module sar_readout_cal #(
  parameter int RES_W = sar_readout_pkg::RES_BITS
) (
  input wire logic CLK_IN,
  input wire logic RST_N_IN,
  input wire logic SCLK_IN,
  input wire logic SEL_N_IN,
  input wire logic [RES_W-1:0] COMPARE_CODE_IN,
  input wire logic [RES_W-1:0] CAL_OFFSET_IN,
  output logic SDO_OUT,
  output logic SDO_OE_OUT,
  output logic INPUTS_CONNECTED_OUT,
  output logic SAMPLE_STROBE_OUT,
  output logic CAL_BUSY_OUT
);
  // SCLK_IN is the link clock. SEL_N_IN comes from the same host and is set up
  // ahead of the first clock fall, so the link logic reads it directly; a sync
  // would lose the first two falls of every frame. Select high also clears the
  // frame state at once, because the host parks its clock between frames.
  // COMPARE_CODE_IN / CAL_OFFSET_IN come from analog logic that is settled by
  // the link clock, so they are treated as link-domain values.
  // RST_N_IN models the power-up reset of the analog supply; nothing else
  // clears the offset store.

  typedef enum {
    ST_IDLE,
    ST_SHIFT,
    ST_TAIL,
    ST_CAL
  } link_state_e;

  // Link-domain two-flop sync of the power-up reset
  logic rst_meta_r;
  logic rst_link_r;
  always_ff @(negedge SCLK_IN) begin
    rst_meta_r <= RST_N_IN;
    rst_link_r <= rst_meta_r;
  end

  // Link-domain state, stepped by serial clock falling edges
  logic [sar_readout_pkg::EDGE_CNT_W-1:0] edge_cnt_r;
  logic [sar_readout_pkg::EDGE_CNT_W-1:0] edge_cnt_nxt;
  logic [RES_W-1:0] shift_r;
  logic [RES_W-1:0] shift_nxt;
  logic [RES_W-1:0] offset_cal_store_r;
  logic [RES_W-1:0] cal_acc_r;
  logic first_frame_r;
  logic cal_frame_r;
  logic bit_r;
  logic cal_run_r;
  logic in_frame;
  logic [RES_W-1:0] corrected;

  assign in_frame = ~SEL_N_IN;
  // Correction saturates at zero so an offset never wraps to full scale
  assign corrected = (COMPARE_CODE_IN > offset_cal_store_r) ?
    RES_W'(COMPARE_CODE_IN - offset_cal_store_r) :
    sar_readout_pkg::NEG_FULL_SCALE_CODE;
  assign edge_cnt_nxt = (edge_cnt_r == '1) ? edge_cnt_r :
    sar_readout_pkg::EDGE_CNT_W'(edge_cnt_r + 1'b1);
  assign shift_nxt = {shift_r[RES_W-2:0], 1'b0};

  // Frame state: cleared the moment select rises, since no clock follows
  always_ff @(negedge SCLK_IN or posedge SEL_N_IN) begin
    if (SEL_N_IN) begin
      edge_cnt_r <= '0;
      bit_r <= 1'b0;
      cal_run_r <= 1'b0;
      cal_frame_r <= 1'b0;
    end else if (!rst_link_r) begin
      edge_cnt_r <= '0;
      bit_r <= 1'b0;
      cal_run_r <= 1'b0;
      cal_frame_r <= 1'b0;
    end else begin
      edge_cnt_r <= edge_cnt_nxt;
      if (edge_cnt_r == '0) begin
        bit_r <= 1'b0;  // Second leading zero
        cal_run_r <= first_frame_r;
        cal_frame_r <= first_frame_r;
      end else if (cal_frame_r) begin
        bit_r <= 1'b0;
        if (edge_cnt_nxt == sar_readout_pkg::EDGE_CNT_W'(sar_readout_pkg::PWRUP_CAL_EDGES)) begin
          cal_run_r <= 1'b0;
        end
      end else begin
        if (edge_cnt_r < sar_readout_pkg::EDGE_CNT_W'(sar_readout_pkg::SHIFT_EDGES)) begin
          bit_r <= shift_r[RES_W-1];
        end else begin
          bit_r <= 1'b0;
        end
        if (edge_cnt_nxt == sar_readout_pkg::EDGE_CNT_W'(sar_readout_pkg::CAL_START_EDGE)) begin
          cal_run_r <= 1'b1;
        end
        if (edge_cnt_nxt == sar_readout_pkg::EDGE_CNT_W'(sar_readout_pkg::CAL_DONE_EDGE)) begin
          cal_run_r <= 1'b0;
        end
      end
    end
  end

  // Result word, calibration value and offset store survive frame ends
  always_ff @(negedge SCLK_IN) begin
    if (!rst_link_r) begin
      shift_r <= '0;
      cal_acc_r <= '0;
      first_frame_r <= 1'b1;
      offset_cal_store_r <= sar_readout_pkg::OFFSET_RESET;
    end else if (in_frame) begin
      if (edge_cnt_r == '0) begin
        // Sample taken on select fall; the SAR word is latched here
        shift_r <= corrected;
        cal_acc_r <= CAL_OFFSET_IN;
        first_frame_r <= 1'b0;
      end else if (cal_frame_r) begin
        if (edge_cnt_nxt == sar_readout_pkg::EDGE_CNT_W'(sar_readout_pkg::PWRUP_CAL_EDGES)) begin
          offset_cal_store_r <= cal_acc_r;
        end
      end else begin
        if (edge_cnt_r < sar_readout_pkg::EDGE_CNT_W'(sar_readout_pkg::SHIFT_EDGES)) begin
          shift_r <= shift_nxt;
        end
        if (edge_cnt_nxt == sar_readout_pkg::EDGE_CNT_W'(sar_readout_pkg::CAL_START_EDGE)) begin
          cal_acc_r <= CAL_OFFSET_IN;
        end
        if (edge_cnt_nxt == sar_readout_pkg::EDGE_CNT_W'(sar_readout_pkg::CAL_DONE_EDGE)) begin
          offset_cal_store_r <= cal_acc_r;
        end
      end
    end
  end

  // Converting from select fall until the last result bit leaves
  logic converting;
  assign converting = in_frame &&
    (edge_cnt_r < sar_readout_pkg::EDGE_CNT_W'(sar_readout_pkg::SHIFT_EDGES));

  // Status handed to the system clock as levels, two flops each
  logic conv_meta_r;
  logic conv_sync_r;
  logic cal_meta_r;
  logic cal_sync_r;
  logic frm_meta_r;
  logic frm_sync_r;
  logic frm_prev_r;
  logic sdo_meta_r;
  logic sdo_sync_r;
  logic sel_c_meta_r;
  logic sel_c_sync_r;
  always_ff @(posedge CLK_IN) begin
    conv_meta_r <= converting;
    conv_sync_r <= conv_meta_r;
    cal_meta_r <= cal_run_r;
    cal_sync_r <= cal_meta_r;
    frm_meta_r <= in_frame;
    frm_sync_r <= frm_meta_r;
    sdo_meta_r <= bit_r;
    sdo_sync_r <= sdo_meta_r;
    sel_c_meta_r <= SEL_N_IN;
    sel_c_sync_r <= sel_c_meta_r;
  end

  logic frame_open;
  logic sample_edge;
  assign frame_open = ~sel_c_sync_r;
  assign sample_edge = frm_sync_r & ~frm_prev_r;

  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      frm_prev_r <= 1'b0;
      SDO_OUT <= 1'b0;
      SDO_OE_OUT <= 1'b0;
      INPUTS_CONNECTED_OUT <= 1'b1;
      SAMPLE_STROBE_OUT <= 1'b0;
      CAL_BUSY_OUT <= 1'b0;
    end else begin
      frm_prev_r <= frm_sync_r;
      SDO_OUT <= frame_open & sdo_sync_r;
      SDO_OE_OUT <= frame_open;
      INPUTS_CONNECTED_OUT <= ~(conv_sync_r | cal_sync_r);
      SAMPLE_STROBE_OUT <= sample_edge;
      CAL_BUSY_OUT <= cal_sync_r;
    end
  end

  chk_sdo_release: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    sel_c_sync_r |=> !SDO_OE_OUT)
    else $error("data output driven outside frame");
  chk_sdo_enable: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    $fell(sel_c_sync_r) |=> SDO_OE_OUT)
    else $error("data output not enabled at frame start");
  chk_low_when_off: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    !SDO_OE_OUT |-> !SDO_OUT)
    else $error("data high while released");
  chk_tail_low: assert property (@(negedge SCLK_IN) disable iff (!rst_link_r)
    (in_frame && edge_cnt_r >= 6'd12) |=> !bit_r)
    else $error("data not low after twelve clocks");
  chk_first_frame_low: assert property (@(negedge SCLK_IN) disable iff (!rst_link_r)
    cal_frame_r |=> !bit_r)
    else $error("data not low in calibration frame");
  chk_store_stable: assert property (@(negedge SCLK_IN) disable iff (!rst_link_r)
    (!(in_frame && cal_frame_r && edge_cnt_nxt == 6'd16) &&
     !(in_frame && edge_cnt_nxt == 6'd32)) |=> $stable(offset_cal_store_r))
    else $error("offset store changed off edges 16 and 32");
  chk_isolated_conv: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    (conv_sync_r || cal_sync_r) |=> !INPUTS_CONNECTED_OUT)
    else $error("inputs connected while converting");
  chk_sample_pulse: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    SAMPLE_STROBE_OUT |=> !SAMPLE_STROBE_OUT)
    else $error("sample strobe longer than one cycle");
endmodule
`default_nettype wire

// [host_model.sv]
// Host controller model driving frame select and serial clock
`timescale 1ns/1ps
`default_nettype none
module host_model;
  logic sclk_out = 1'b1;
  logic sel_n_out = 1'b1;
  logic [11:0] word;
  logic tail_bad, oe_first, conn_mid, busy_mid, busy_late;
  wire logic sdo_in = testbench.SDO_OUT;
  wire logic oe_in = testbench.SDO_OE_OUT;

  // Clock pulses with select high, used only to move reset into the link domain
  task automatic pulses(input int n);
    repeat (n) begin
      sclk_out = 1'b0;
      #80;
      sclk_out = 1'b1;
      #80;
    end
  endtask

  // Serial clock stands still high outside frames
  task automatic frame(input int n);
    word = '0;
    tail_bad = 1'b0;
    sel_n_out = 1'b0;
    #(sar_readout_pkg::SETUP_NS + 5);
    word = {11'h000, sdo_in};
    for (int k = 1; k <= n; k++) begin
      sclk_out = 1'b0;
      #80;
      sclk_out = 1'b1;
      if (k <= 11) word = {word[10:0], sdo_in};
      if (k == 1) oe_first = oe_in;
      if (k >= 12 && sdo_in !== 1'b0) tail_bad = 1'b1;
      if (k == 5) conn_mid = testbench.INPUTS_CONNECTED_OUT;
      if (k == 8) busy_mid = testbench.CAL_BUSY_OUT;
      if (k == 24) busy_late = testbench.CAL_BUSY_OUT;
      #80;
    end
    #10 sel_n_out = 1'b1;
    #(sar_readout_pkg::ACQ_NS + 5);
  endtask
endmodule
`default_nettype wire

// [testbench.sv]
// Self-checking bench for the converter readout block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic CLK_IN = 1'b0;
  logic RST_N_IN = 1'b0;
  logic [9:0] COMPARE_CODE_IN = '0;
  logic [9:0] CAL_OFFSET_IN = '0;
  logic SDO_OUT, SDO_OE_OUT, INPUTS_CONNECTED_OUT, SAMPLE_STROBE_OUT, CAL_BUSY_OUT;
  int error_cnt = 0;
  int n_tests = 0;
  int strobes = 0;
  int cycles = 0;
  logic [9:0] codes [3] = '{10'h000, 10'h200, 10'h3FF};

  host_model host();
  sar_readout_cal uut (.CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN), .SCLK_IN(host.sclk_out),
    .SEL_N_IN(host.sel_n_out), .COMPARE_CODE_IN(COMPARE_CODE_IN),
    .CAL_OFFSET_IN(CAL_OFFSET_IN), .SDO_OUT(SDO_OUT), .SDO_OE_OUT(SDO_OE_OUT),
    .INPUTS_CONNECTED_OUT(INPUTS_CONNECTED_OUT), .SAMPLE_STROBE_OUT(SAMPLE_STROBE_OUT),
    .CAL_BUSY_OUT(CAL_BUSY_OUT));

  initial begin
    forever #2 CLK_IN = ~CLK_IN;
  end

  always @(posedge CLK_IN) begin
    if (SAMPLE_STROBE_OUT === 1'b1) strobes++;
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("checks=%0d mismatches=%0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Reset must also be seen on link clock falls, so it spans three of them
  task automatic do_reset();
    @(posedge CLK_IN) RST_N_IN <= 1'b0;
    host.pulses(3);
    @(posedge CLK_IN) RST_N_IN <= 1'b1;
    host.pulses(4);
    repeat (4) @(posedge CLK_IN);
  endtask

  task automatic xfer(input int n, input logic [9:0] code, input logic [9:0] off);
    int s0;
    @(posedge CLK_IN);
    COMPARE_CODE_IN <= code;
    CAL_OFFSET_IN <= off;
    s0 = strobes;
    host.frame(n);
    chk(12'(strobes - s0), 12'h001);
    chk({11'h000, host.oe_first}, 12'h001);
    chk({11'h000, SDO_OE_OUT}, 12'h000);
    chk({11'h000, host.conn_mid}, 12'h000);
    chk({11'h000, INPUTS_CONNECTED_OUT}, 12'h001);
    chk({11'h000, host.tail_bad}, 12'h000);
  endtask

  task automatic first_short();
    do_reset();
    xfer(10, 10'h3FF, 10'h055);
    chk(host.word, 12'h000);
    chk({11'h000, host.busy_mid}, 12'h001);
    foreach (codes[i]) begin
      xfer(13, codes[i], 10'h3AA);
      chk(host.word, {2'b00, codes[i]});
    end
  endtask

  task automatic first_full();
    do_reset();
    xfer(16, 10'h000, 10'h010);
    chk(host.word, 12'h000);
    xfer(13, 10'h200, 10'h000);
    chk(host.word, 12'h1F0);
    xfer(13, 10'h005, 10'h000);
    chk(host.word, 12'h000);
  endtask

  task automatic recal();
    xfer(20, 10'h123, 10'h020);
    chk(host.word, 12'h113);
    xfer(13, 10'h200, 10'h000);
    chk(host.word, 12'h1F0);
    xfer(32, 10'h100, 10'h004);
    chk(host.word, 12'h0F0);
    chk({11'h000, host.busy_late}, 12'h001);
    xfer(13, 10'h3FF, 10'h000);
    chk(host.word, 12'h3FB);
  endtask

  initial begin
    first_short();
    first_full();
    recal();
    stop_test();
  end
endmodule
`default_nettype wire
